/* gcr_pkg.sv */
package gcr_pkg;

  // Bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_WAVE_BASE = 16'hE400;
  localparam int WAVE_DEPTH = 128;
  localparam logic [15:0] IDX_CPU_CTRL = 16'hE600;
  localparam logic [15:0] IDX_IF_CFG = 16'hE601;
  localparam logic [15:0] IDX_FLAG_AB = 16'hE602;
  localparam logic [15:0] IDX_FLAG_CD = 16'hE603;
  localparam logic [15:0] IDX_FIFO_RST = 16'hE604;
  localparam logic [15:0] IDX_BRK_CTRL = 16'hE605;
  localparam logic [15:0] IDX_BP_HIGH = 16'hE606;
  localparam logic [15:0] IDX_WF_SELECT = 16'hE6F0;

  // Values after hard reset
  localparam logic [7:0] RST_CPU_CTRL = 8'h02;
  localparam logic [7:0] RST_IF_CFG = 8'h80;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_BRK_CTRL = 8'h00;
  localparam logic [7:0] RST_BP_HIGH = 8'h00;
  localparam logic [1:0] RST_WF_SELECT = 2'h0;

  // Writable bit masks; other bits are fixed at zero, except breakpoint status bit 3
  localparam logic [7:0] CPU_WMASK = 8'h3F;
  localparam logic [7:0] BRK_WMASK = 8'h06;

  // Processor control fields
  localparam int CPU_STB_BIT = 5;
  localparam int CPU_SPD_LSB = 3;
  localparam int CPU_INV_BIT = 2;
  localparam int CPU_OE_BIT = 1;
  localparam int CPU_RES_BIT = 0;

  // Interface configuration fields
  localparam int IF_SRC_BIT = 7;
  localparam int IF_FREQ_BIT = 6;
  localparam int IF_OE_BIT = 5;
  localparam int IF_POL_BIT = 4;
  localparam int IF_FIFO_SELECT_A_BIT = 3;
  localparam int IF_STATE_BIT = 2;
  localparam int IF_MODE_LSB = 0;

  // Breakpoint control fields
  localparam int BRK_STAT_BIT = 3;
  localparam int BRK_PULSE_BIT = 2;
  localparam int BRK_EN_BIT = 1;

  // FIFO restore fields
  localparam int RST_REFUSE_BIT = 7;

  // Processor clock speed codes
  localparam logic [1:0] SPD_12 = 2'b00;
  localparam logic [1:0] SPD_24 = 2'b01;
  localparam logic [1:0] SPD_48 = 2'b10;
  localparam logic [1:0] SPD_BAD = 2'b11;

  // Interface mode codes
  localparam logic [1:0] MODE_PORTS = 2'b00;
  localparam logic [1:0] MODE_WAVE = 2'b10;
  localparam logic [1:0] MODE_SLAVE = 2'b11;

  // Flag selector groups (upper two bits of a selector)
  localparam logic [1:0] FGRP_ADDR = 2'b00;
  localparam logic [1:0] FGRP_PROG = 2'b01;
  localparam logic [1:0] FGRP_EMPTY = 2'b10;
  localparam logic [1:0] FGRP_FULL = 2'b11;

  // FIFO numbers that a restore may name
  localparam logic [3:0] FIFO_EP2 = 4'h2;
  localparam logic [3:0] FIFO_EP4 = 4'h4;
  localparam logic [3:0] FIFO_EP6 = 4'h6;
  localparam logic [3:0] FIFO_EP8 = 4'h8;

endpackage : gcr_pkg

/* gcr_regs.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Function
// - Fixed bits ignore writes, read constant
// - Registers take default value at reset
// - 128-byte waveform memory, select register
// - Port C access pulses strobes when enabled
// - Clock speed code 00/01/10, 11 invalid
// - Clock out enable and invert
// - Reset bit holds processor in reset
// - Interface clock source external or internal
// - Internal interface clock 30 or 48 MHz
// - Interface clock output enable and polarity
// - Slave FIFO asynchronous or synchronous mode
// - State bits drive port E 0..2
// - Interface mode ports, waveform, slave FIFO
// - Four flag pins, four-bit selector each
// - Flag selector codes choose flag source
// - Restore write resets named FIFO flags
// - Restore sequence: refuse, name, resume
module gcr_regs
  import gcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [gcr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [gcr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_portc_rd,
  input wire logic cpu_portc_wr,
  output logic portc_rd_strobe_n,
  output logic portc_wr_strobe_n,
  output logic [1:0] cpu_clock_speed,
  output logic cpu_clock_valid,
  input wire logic cpu_clock,
  output logic processor_clock_pin_o,
  output logic processor_clock_pin_oe,
  output logic processor_reset,
  input wire logic interface_clock_pin_i,
  input wire logic int_clock_30,
  input wire logic int_clock_48,
  output logic interface_clock,
  output logic interface_clock_pin_o,
  output logic interface_clock_pin_oe,
  output logic fifo_fifo_select_a,
  input wire logic [2:0] waveform_state,
  input wire logic [2:0] port_e_gpio_o,
  input wire logic [2:0] port_e_gpio_oe,
  output logic [2:0] port_e_b_o,
  output logic [2:0] port_e_b_oe,
  output logic mode_ports,
  output logic mode_waveform,
  output logic mode_slave_fifo,
  input wire logic [1:0] fifo_address_pins,
  input wire logic [3:0] ep_programmable_flag,
  input wire logic [3:0] ep_empty_flag,
  input wire logic [3:0] ep_full_flag,
  output logic [3:0] flag_pin,
  output logic refuse_all_transfers,
  output logic fifo_restore_pulse,
  output logic [3:0] fifo_restore_num,
  input wire logic [4:0] wf_rd_index,
  output logic [7:0] wf_rd_data,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] bp_addr_low,
  output logic break_status
);
  import gcr_pkg::*;

  // Register storage
  logic [7:0] cpu_control_reg;
  logic [7:0] interface_config_reg;
  logic [7:0] flag_ab_select_reg;
  logic [7:0] flag_cd_select_reg;
  logic [7:0] breakpoint_control_reg;
  logic [7:0] breakpoint_addr_high;
  logic [1:0] waveform_select;
  logic [7:0] waveform_memory [WAVE_DEPTH];

  // Bus decode
  logic [15:0] idx;
  logic addr_ok;
  logic acc;
  logic wr_en;
  logic bp_hit;

  // True when the index falls inside the waveform memory
  function automatic logic is_wave(input logic [15:0] i);
    is_wave = (i >= IDX_WAVE_BASE) && (i < IDX_WAVE_BASE + 16'(WAVE_DEPTH));
  endfunction : is_wave

  // True when the index names any mapped register
  function automatic logic is_mapped(input logic [15:0] i);
    is_mapped = is_wave(i) || (i >= IDX_CPU_CTRL && i <= IDX_BP_HIGH) || (i == IDX_WF_SELECT);
  endfunction : is_mapped

  // Flag source chosen by one selector
  function automatic logic flag_of(input logic [3:0] sel, input logic [1:0] fa,
                                   input logic [3:0] prg, input logic [3:0] emp,
                                   input logic [3:0] ful);
    case (sel[3:2])
      FGRP_ADDR: flag_of = (sel[1:0] == 2'b00) ? prg[fa] : 1'b0;
      FGRP_PROG: flag_of = prg[sel[1:0]];
      FGRP_EMPTY: flag_of = emp[sel[1:0]];
      FGRP_FULL: flag_of = ful[sel[1:0]];
      default: flag_of = 1'b0;
    endcase
  endfunction : flag_of

  // Read value of one index; fixed bits come back as zero
  function automatic logic [7:0] read_value(input logic [15:0] i);
    if (is_wave(i)) begin
      read_value = waveform_memory[i[6:0]];
    end else begin
      case (i)
        IDX_CPU_CTRL: read_value = cpu_control_reg & CPU_WMASK;
        IDX_IF_CFG: read_value = interface_config_reg;
        IDX_FLAG_AB: read_value = flag_ab_select_reg;
        IDX_FLAG_CD: read_value = flag_cd_select_reg;
        IDX_BRK_CTRL: read_value = breakpoint_control_reg & (BRK_WMASK | 8'h08);
        IDX_BP_HIGH: read_value = breakpoint_addr_high;
        IDX_WF_SELECT: read_value = {6'h00, waveform_select};
        default: read_value = 8'h00; // Write-only restore and holes read zero
      endcase
    end
  endfunction : read_value

  // Address split and error check
  assign idx = paddr[17:2];
  assign addr_ok = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'b00) && is_mapped(idx);
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && addr_ok && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = acc && !addr_ok;

  // Read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, addr_ok ? read_value(idx) : 8'h00};
    end
  end

  // Waveform memory, undefined after reset
  always_ff @(posedge pclk) begin
    if (wr_en && is_wave(idx)) begin
      waveform_memory[idx[6:0]] <= pwdata[7:0];
    end
  end

  // Waveform engine read port inside the selected descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wf_rd_data <= 8'h00;
    end else begin
      wf_rd_data <= waveform_memory[{waveform_select, wf_rd_index}];
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_control_reg <= RST_CPU_CTRL;
      interface_config_reg <= RST_IF_CFG;
      flag_ab_select_reg <= RST_FLAG;
      flag_cd_select_reg <= RST_FLAG;
      breakpoint_addr_high <= RST_BP_HIGH;
      waveform_select <= RST_WF_SELECT;
    end else if (wr_en) begin
      case (idx)
        IDX_CPU_CTRL: cpu_control_reg <= pwdata[7:0] & CPU_WMASK;
        IDX_IF_CFG: interface_config_reg <= pwdata[7:0];
        IDX_FLAG_AB: flag_ab_select_reg <= pwdata[7:0];
        IDX_FLAG_CD: flag_cd_select_reg <= pwdata[7:0];
        IDX_BP_HIGH: breakpoint_addr_high <= pwdata[7:0];
        IDX_WF_SELECT: waveform_select <= pwdata[1:0];
        default: ; // Other indices hold elsewhere
      endcase
    end
  end

  // Breakpoint control: enable and pulse mode from software, status from the match
  assign bp_hit = breakpoint_control_reg[BRK_EN_BIT] && fetch_valid &&
                  (fetch_addr == {breakpoint_addr_high, bp_addr_low});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breakpoint_control_reg <= RST_BRK_CTRL;
    end else begin
      if (wr_en && idx == IDX_BRK_CTRL) begin
        breakpoint_control_reg[BRK_EN_BIT] <= pwdata[BRK_EN_BIT];
        breakpoint_control_reg[BRK_PULSE_BIT] <= pwdata[BRK_PULSE_BIT];
      end
      // A match wins over a clear in the same cycle
      if (bp_hit) begin
        breakpoint_control_reg[BRK_STAT_BIT] <= 1'b1;
      end else if (breakpoint_control_reg[BRK_PULSE_BIT]) begin
        breakpoint_control_reg[BRK_STAT_BIT] <= 1'b0;
      end else if (wr_en && idx == IDX_BRK_CTRL && pwdata[BRK_STAT_BIT]) begin
        breakpoint_control_reg[BRK_STAT_BIT] <= 1'b0;
      end
    end
  end
  assign break_status = breakpoint_control_reg[BRK_STAT_BIT];

  // FIFO restore: refuse-all level and the restore pulse for a named FIFO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refuse_all_transfers <= 1'b0;
      fifo_restore_pulse <= 1'b0;
      fifo_restore_num <= 4'h0;
    end else begin
      fifo_restore_pulse <= 1'b0;
      if (wr_en && idx == IDX_FIFO_RST) begin
        refuse_all_transfers <= pwdata[RST_REFUSE_BIT];
        // Only honoured while transfers are already refused
        if (refuse_all_transfers && pwdata[RST_REFUSE_BIT] &&
            (pwdata[3:0] == FIFO_EP2 || pwdata[3:0] == FIFO_EP4 ||
             pwdata[3:0] == FIFO_EP6 || pwdata[3:0] == FIFO_EP8)) begin
          fifo_restore_pulse <= 1'b1;
          fifo_restore_num <= pwdata[3:0];
        end
      end
    end
  end

  // Port C strobes, active low for one cycle per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portc_rd_strobe_n <= 1'b1;
      portc_wr_strobe_n <= 1'b1;
    end else begin
      portc_rd_strobe_n <= !(cpu_control_reg[CPU_STB_BIT] && cpu_portc_rd);
      portc_wr_strobe_n <= !(cpu_control_reg[CPU_STB_BIT] && cpu_portc_wr);
    end
  end

  // Processor clock speed and reset
  assign cpu_clock_speed = cpu_control_reg[CPU_SPD_LSB +: 2];
  assign cpu_clock_valid = (cpu_clock_speed != SPD_BAD);
  assign processor_reset = cpu_control_reg[CPU_RES_BIT];

  // Processor clock output pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_clock_pin_o <= 1'b0;
      processor_clock_pin_oe <= 1'b0;
    end else begin
      processor_clock_pin_o <= cpu_clock ^ cpu_control_reg[CPU_INV_BIT];
      processor_clock_pin_oe <= cpu_control_reg[CPU_OE_BIT];
    end
  end

  // Interface clock source, frequency, pin drive and polarity
  assign interface_clock = interface_config_reg[IF_SRC_BIT] ?
      (interface_config_reg[IF_FREQ_BIT] ? int_clock_48 : int_clock_30) :
      interface_clock_pin_i;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interface_clock_pin_o <= 1'b0;
      interface_clock_pin_oe <= 1'b0;
    end else begin
      interface_clock_pin_o <= interface_clock ^ interface_config_reg[IF_POL_BIT];
      interface_clock_pin_oe <= interface_config_reg[IF_OE_BIT];
    end
  end

  // FIFO timing and interface mode decode
  assign fifo_fifo_select_a = interface_config_reg[IF_FIFO_SELECT_A_BIT];
  assign mode_ports = interface_config_reg[IF_MODE_LSB +: 2] == MODE_PORTS;
  assign mode_waveform = interface_config_reg[IF_MODE_LSB +: 2] == MODE_WAVE;
  assign mode_slave_fifo = interface_config_reg[IF_MODE_LSB +: 2] == MODE_SLAVE;

  // Port E low bits: waveform state or ordinary port drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_b_o <= 3'h0;
      port_e_b_oe <= 3'h0;
    end else if (interface_config_reg[IF_STATE_BIT]) begin
      port_e_b_o <= waveform_state;
      port_e_b_oe <= 3'h7;
    end else begin
      port_e_b_o <= port_e_gpio_o;
      port_e_b_oe <= port_e_gpio_oe;
    end
  end

  // Flag pins, one selector each
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      logic [3:0] sel;
      assign sel = (g < 2) ? flag_ab_select_reg[4*(g%2) +: 4] :
                             flag_cd_select_reg[4*(g%2) +: 4];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_pin[g] <= 1'b0;
        end else begin
          flag_pin[g] <= flag_of(sel, fifo_address_pins, ep_programmable_flag,
                                 ep_empty_flag, ep_full_flag);
        end
      end
    end
  endgenerate

  // Checks
  property p_fixed_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == {14'h0000, IDX_CPU_CTRL, 2'b00}) |=>
      (prdata[7:6] == 2'b00);
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed cpu bits not zero");

  property p_reset_vals;
    @(posedge pclk) disable iff (!presetn)
    $past(!presetn) |-> (cpu_control_reg == RST_CPU_CTRL && interface_config_reg == RST_IF_CFG
                         && !break_status);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

  property p_wave_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && is_wave(idx)) |=> (waveform_memory[$past(idx[6:0])] == $past(pwdata[7:0]));
  endproperty
  a_wave_wr: assert property (p_wave_wr) else $error("waveform write lost");

  property p_strobe;
    @(posedge pclk) disable iff (!presetn)
    (cpu_portc_wr && cpu_control_reg[CPU_STB_BIT]) |=> !portc_wr_strobe_n ##1
      (portc_wr_strobe_n || $past(cpu_portc_wr));
  endproperty
  a_strobe: assert property (p_strobe) else $error("port c write strobe wrong");

  property p_no_strobe;
    @(posedge pclk) disable iff (!presetn)
    !cpu_control_reg[CPU_STB_BIT] |=> (portc_rd_strobe_n && portc_wr_strobe_n);
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("strobe while disabled");

  property p_cpu_reset;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == IDX_CPU_CTRL) |=> (processor_reset == $past(pwdata[CPU_RES_BIT]))
      && (processor_clock_pin_oe == $past(processor_clock_pin_oe));
  endproperty
  a_cpu_reset: assert property (p_cpu_reset) else $error("processor reset bit wrong");

  property p_state_out;
    @(posedge pclk) disable iff (!presetn)
    interface_config_reg[IF_STATE_BIT] |=> (port_e_b_o == $past(waveform_state));
  endproperty
  a_state_out: assert property (p_state_out) else $error("port e state not driven");

  property p_flag_full;
    @(posedge pclk) disable iff (!presetn)
    (flag_ab_select_reg[3:0] == 4'hC) |=> (flag_pin[0] == $past(ep_full_flag[0]));
  endproperty
  a_flag_full: assert property (p_flag_full) else $error("flag a full source wrong");

  property p_restore_seq;
    @(posedge pclk) disable iff (!presetn)
    $rose(fifo_restore_pulse) |-> ($past(refuse_all_transfers) && refuse_all_transfers)
      ##1 !fifo_restore_pulse[*1];
  endproperty
  a_restore_seq: assert property (p_restore_seq) else $error("restore outside sequence");

  property p_break_pulse;
    @(posedge pclk) disable iff (!presetn)
    (break_status && breakpoint_control_reg[BRK_PULSE_BIT] && !bp_hit) |=> !break_status;
  endproperty
  a_break_pulse: assert property (p_break_pulse) else $error("break pulse stuck");

  c_restore: cover property (@(posedge pclk) disable iff (!presetn) fifo_restore_pulse);
  c_break: cover property (@(posedge pclk) disable iff (!presetn) $rose(break_status));
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_slave_mode: cover property (@(posedge pclk) disable iff (!presetn) mode_slave_fifo);

endmodule : gcr_regs

/* test_general_config_registers.sv */
`timescale 1ns/1ps
// Self-checking bench for the configuration register bank
module test_general_config_registers;
  import gcr_pkg::*;

  // Bus side signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  // Device side inputs
  logic cpu_portc_rd, cpu_portc_wr, cpu_clock, interface_clock_pin_i;
  logic int_clock_30, int_clock_48, fetch_valid;
  logic [2:0] waveform_state, port_e_gpio_o, port_e_gpio_oe;
  logic [1:0] fifo_address_pins;
  logic [3:0] ep_programmable_flag, ep_empty_flag, ep_full_flag;
  logic [4:0] wf_rd_index;
  logic [15:0] fetch_addr;
  logic [7:0] bp_addr_low;
  // Device side outputs
  logic portc_rd_strobe_n, portc_wr_strobe_n, cpu_clock_valid, processor_clock_pin_o;
  logic processor_clock_pin_oe, processor_reset, interface_clock, interface_clock_pin_o;
  logic interface_clock_pin_oe, fifo_fifo_select_a, mode_ports, mode_waveform, mode_slave_fifo;
  logic refuse_all_transfers, fifo_restore_pulse, break_status;
  logic [1:0] cpu_clock_speed;
  logic [2:0] port_e_b_o, port_e_b_oe;
  logic [3:0] flag_pin, fifo_restore_num;
  logic [7:0] wf_rd_data;
  // Bookkeeping
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] ifv [4] = '{8'h00, 8'hD5, 8'hAA, 8'h6F};
  logic [3:0] fifo_ids [4] = '{FIFO_EP2, FIFO_EP4, FIFO_EP6, FIFO_EP8};
  logic [2:0] pat;
  logic iclk;
  logic [31:0] rdat;
  logic rerr;

  gcr_regs u_gcr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cpu_portc_rd, .cpu_portc_wr, .portc_rd_strobe_n,
    .portc_wr_strobe_n, .cpu_clock_speed, .cpu_clock_valid, .cpu_clock,
    .processor_clock_pin_o, .processor_clock_pin_oe, .processor_reset,
    .interface_clock_pin_i, .int_clock_30, .int_clock_48, .interface_clock,
    .interface_clock_pin_o, .interface_clock_pin_oe, .fifo_fifo_select_a, .waveform_state,
    .port_e_gpio_o, .port_e_gpio_oe, .port_e_b_o, .port_e_b_oe, .mode_ports, .mode_waveform,
    .mode_slave_fifo, .fifo_address_pins, .ep_programmable_flag, .ep_empty_flag,
    .ep_full_flag, .flag_pin, .refuse_all_transfers, .fifo_restore_pulse, .fifo_restore_num,
    .wf_rd_index, .wf_rd_data, .fetch_valid, .fetch_addr, .bp_addr_low, .break_status);

  // Clock of 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard: far above the few hundred cycles of the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      $display("[ERR] run length expected below 5000 seen %0d", cycles);
      wrap_up();
    end
  end

  // Prints counts and verdict, then stops
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Compare of a byte value
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk8

  // Compare of a single bit
  task automatic chk1(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk1

  // Let n edges pass, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  // One APB transfer: setup, access held until pready at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write by index
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, {14'h0, idx, 2'b00}, {24'h0, d}, rdat, rerr);
  endtask : wr

  // Register read by index with expected byte
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, {14'h0, idx, 2'b00}, 32'h0, rdat, rerr);
    chk8("read data", exp, rdat[7:0]);
  endtask : rd

  // Expected level of a flag pin for a selector code
  function automatic logic flag_exp(input logic [3:0] c);
    case (c[3:2])
      FGRP_ADDR: flag_exp = (c == 4'h0) ? ep_programmable_flag[fifo_address_pins] : 1'b0;
      FGRP_PROG: flag_exp = ep_programmable_flag[c[1:0]];
      FGRP_EMPTY: flag_exp = ep_empty_flag[c[1:0]];
      default: flag_exp = ep_full_flag[c[1:0]];
    endcase
  endfunction : flag_exp

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_portc_rd, cpu_portc_wr, fetch_valid} = '0;
    {cpu_clock, interface_clock_pin_i, int_clock_30, int_clock_48} = 4'h0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    waveform_state = 3'b101;
    port_e_gpio_o = 3'b010;
    port_e_gpio_oe = 3'b011;
    fifo_address_pins = 2'b01;
    ep_programmable_flag = 4'b1010;
    ep_empty_flag = 4'b0110;
    ep_full_flag = 4'b0011;
    wf_rd_index = 5'h0;
    fetch_addr = 16'h0;
    bp_addr_low = 8'h34;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults after reset
    rd(IDX_CPU_CTRL, RST_CPU_CTRL);
    rd(IDX_IF_CFG, RST_IF_CFG);
    rd(IDX_FLAG_AB, RST_FLAG);
    rd(IDX_FLAG_CD, RST_FLAG);
    rd(IDX_BRK_CTRL, RST_BRK_CTRL);
    $display("test reset values done");
    // Fixed bits ignore writes
    wr(IDX_CPU_CTRL, 8'hFF);
    rd(IDX_CPU_CTRL, CPU_WMASK);
    chk1("processor reset", 1'b1, processor_reset);
    wr(IDX_BRK_CTRL, 8'hFF);
    rd(IDX_BRK_CTRL, BRK_WMASK);
    // Every clock speed code, with reset released
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CPU_CTRL, {3'b000, c[1:0], 3'b000});
      #1;
      chk8("clock speed", {6'h0, c[1:0]}, {6'h0, cpu_clock_speed});
      chk1("clock valid", c[1:0] != SPD_BAD, cpu_clock_valid);
      chk1("processor reset", 1'b0, processor_reset);
    end
    $display("test processor control done");
    // Clock output pin enable and invert
    @(posedge pclk);
    cpu_clock <= 1'b1;
    wr(IDX_CPU_CTRL, 8'h02);
    settle(2);
    chk1("clock pin", 1'b1, processor_clock_pin_o);
    chk1("clock pin enable", 1'b1, processor_clock_pin_oe);
    wr(IDX_CPU_CTRL, 8'h04);
    settle(2);
    chk1("clock pin", 1'b0, processor_clock_pin_o);
    chk1("clock pin enable", 1'b0, processor_clock_pin_oe);
    // Port C strobes, enabled then disabled
    for (int en = 1; en >= 0; en--) begin
      wr(IDX_CPU_CTRL, en[0] ? 8'h20 : 8'h00);
      @(posedge pclk);
      cpu_portc_rd <= 1'b1;
      @(posedge pclk);
      cpu_portc_rd <= 1'b0;
      cpu_portc_wr <= 1'b1;
      #1;
      chk1("read strobe", ~en[0], portc_rd_strobe_n);
      @(posedge pclk);
      cpu_portc_wr <= 1'b0;
      #1;
      chk1("write strobe", ~en[0], portc_wr_strobe_n);
      settle(1);
      chk1("write strobe idle", 1'b1, portc_wr_strobe_n);
    end
    $display("test clock and strobes done");
    // Interface configuration values over two clock patterns
    foreach (ifv[i]) begin
      wr(IDX_IF_CFG, ifv[i]);
      rd(IDX_IF_CFG, ifv[i]);
      for (int p = 0; p < 2; p++) begin
        pat = p[0] ? 3'b010 : 3'b100;
        @(posedge pclk);
        {interface_clock_pin_i, int_clock_30, int_clock_48} <= pat;
        settle(2);
        iclk = ifv[i][7] ? (ifv[i][6] ? pat[0] : pat[1]) : pat[2];
        chk1("interface clock", iclk, interface_clock);
        chk1("interface clock pin", iclk ^ ifv[i][4], interface_clock_pin_o);
      end
      chk1("interface clock enable", ifv[i][5], interface_clock_pin_oe);
      chk1("fifo fifo_select_a", ifv[i][3], fifo_fifo_select_a);
      chk8("port e out", ifv[i][2] ? 8'h05 : 8'h02, {5'h0, port_e_b_o});
      chk8("port e enable", ifv[i][2] ? 8'h07 : 8'h03, {5'h0, port_e_b_oe});
      chk1("mode ports", ifv[i][1:0] == MODE_PORTS, mode_ports);
      chk1("mode waveform", ifv[i][1:0] == MODE_WAVE, mode_waveform);
      chk1("mode slave", ifv[i][1:0] == MODE_SLAVE, mode_slave_fifo);
    end
    $display("test interface configuration done");
    // Every flag selector code on all four pins
    for (int c = 0; c < 16; c++) begin
      wr(IDX_FLAG_AB, {~c[3:0], c[3:0]});
      wr(IDX_FLAG_CD, {c[3:0] ^ 4'h9, c[3:0] ^ 4'h6});
      settle(2);
      chk1("flag a", flag_exp(c[3:0]), flag_pin[0]);
      chk1("flag b", flag_exp(~c[3:0]), flag_pin[1]);
      chk1("flag c", flag_exp(c[3:0] ^ 4'h6), flag_pin[2]);
      chk1("flag d", flag_exp(c[3:0] ^ 4'h9), flag_pin[3]);
    end
    $display("test flag selectors done");
    // Restore sequence for every FIFO, then a stray write
    wr(IDX_FIFO_RST, 8'h80);
    #1;
    chk1("refuse all", 1'b1, refuse_all_transfers);
    foreach (fifo_ids[i]) begin
      wr(IDX_FIFO_RST, {4'h8, fifo_ids[i]});
      #1;
      chk1("restore pulse", 1'b1, fifo_restore_pulse);
      chk8("restore fifo", {4'h0, fifo_ids[i]}, {4'h0, fifo_restore_num});
      settle(1);
      chk1("restore pulse end", 1'b0, fifo_restore_pulse);
    end
    wr(IDX_FIFO_RST, 8'h00);
    #1;
    chk1("refuse all", 1'b0, refuse_all_transfers);
    // Refuse bit and FIFO number in one write, with no refuse before it
    wr(IDX_FIFO_RST, {4'h8, FIFO_EP4});
    #1;
    chk1("restore without refuse", 1'b0, fifo_restore_pulse);
    rd(IDX_FIFO_RST, 8'h00);
    $display("test fifo restore done");
    // Waveform memory and descriptor select
    wr(IDX_WAVE_BASE + 16'h25, 8'hA5);
    wr(IDX_WAVE_BASE + 16'h7F, 8'h3C);
    rd(IDX_WAVE_BASE + 16'h25, 8'hA5);
    rd(IDX_WAVE_BASE + 16'h7F, 8'h3C);
    wr(IDX_WF_SELECT, 8'h01);
    @(posedge pclk);
    wf_rd_index <= 5'd5;
    settle(2);
    chk8("descriptor byte", 8'hA5, wf_rd_data);
    wr(IDX_WF_SELECT, 8'h03);
    @(posedge pclk);
    wf_rd_index <= 5'd31;
    settle(2);
    chk8("descriptor byte", 8'h3C, wf_rd_data);
    apb(1'b0, {14'h0, IDX_WAVE_BASE + 16'h80, 2'b00}, 32'h0, rdat, rerr);
    chk1("unmapped error", 1'b1, rerr);
    $display("test waveform memory done");
    // Breakpoint: sticky hit, clear, pulse hit, miss
    wr(IDX_BP_HIGH, 8'h12);
    rd(IDX_BP_HIGH, 8'h12);
    for (int m = 0; m < 3; m++) begin
      wr(IDX_BRK_CTRL, m == 0 ? 8'h02 : 8'h06);
      @(posedge pclk);
      fetch_valid <= 1'b1;
      fetch_addr <= (m == 2) ? 16'h1235 : 16'h1234;
      @(posedge pclk);
      fetch_valid <= 1'b0;
      #1;
      chk1("break hit", m != 2, break_status);
      settle(1);
      chk1("break after", m == 0, break_status);
      if (m == 0) begin
        rd(IDX_BRK_CTRL, 8'h0A);
        wr(IDX_BRK_CTRL, 8'h0A);
        rd(IDX_BRK_CTRL, 8'h02);
      end
    end
    $display("test breakpoint done");
    wrap_up();
  end

endmodule : test_general_config_registers
